// ---- rtl/acc_map.svh ----
// constants of the analog compare control block: offsets, fields, resets
// assumes a 32-bit bus with one aligned word per register index
//
// Summary of operation
// - result bit high when positive exceeds negative
// - mux enable, converter off: channel drives negative
// - shared mux usable only without converter power-reduce
// - power-off bit seven switches comparator off
// - bandgap select bit six feeds positive input
// - result synchronised, visible after one-two cycles
// - edge mode: toggle, reserved, falling, rising
// - selected output event sets the event flag
// - interrupt vectoring clears the event flag
// - writing one clears flag, zero keeps it
// - request needs flag, enable and global enable
// - capture route connects result to timer capture
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// ***************************************************************
// register indices (byte address is four times the index)
// ***************************************************************
`define ACC_IDX_CSR 10'h050
`define ACC_IDX_CTLB 10'h07b
`define ACC_IDX_MUX 10'h080
`define ACC_IDX_ISTAT 10'h081
`define ACC_IDX_IMASK 10'h082

// ***************************************************************
// field positions
// ***************************************************************
`define ACC_CSR_POWER_OFF 7
`define ACC_CSR_BANDGAP 6
`define ACC_CSR_RESULT 5
`define ACC_CSR_FLAG 4
`define ACC_CSR_IRQ_EN 3
`define ACC_CSR_ROUTE 2
`define ACC_CTLB_MUX_EN 6
`define ACC_MUX_CONV_EN 3
`define ACC_MUX_POWER_REDUCE 4
`define ACC_IRQ_BIT 0

// ***************************************************************
// reset values and timing
// ***************************************************************
`define ACC_CSR_RESET 8'h00
`define ACC_CTLB_RESET 8'h00
`define ACC_MUX_RESET 8'h00
`define ACC_SYNC_STAGES 2
`define ACC_CLOCK_NS 20

`endif

// ---- rtl/acc_pkg.sv ----
// types shared by the analog compare control files
// assumes the constants header is included by users as needed
package acc_pkg;

   // ***************************************************************
   // edge mode encodings
   // ***************************************************************
   typedef enum logic [1:0] {
      ACC_EDGE_TOGGLE = 2'b00,
      ACC_EDGE_RESERVED = 2'b01,
      ACC_EDGE_FALL = 2'b10,
      ACC_EDGE_RISE = 2'b11
   } acc_edge_mode_type;

endpackage

// ---- rtl/acc_sync.sv ----
// level synchroniser chain for the raw comparator output
// assumes the input may change at any time relative to the clock
`timescale 1ns/10ps
module acc_sync #(
   parameter int STAGES = 2
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic d_in,
   output logic q_out
);

   // ***************************************************************
   // elaboration check
   // ***************************************************************
   generate
      if (STAGES < 2) begin : g_bad
         $error("acc_sync needs at least two stages");
      end
   endgenerate

   // flop chain; first stage feeds only the next stage
   logic [STAGES-1:0] chain_r;

   // shift the level along the chain
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chain_r <= '0;
      end else begin
         chain_r <= {chain_r[STAGES-2:0], d_in};
      end
   end

   assign q_out = chain_r[STAGES-1];

endmodule

// ---- rtl/acc_top.sv ----
// analog compare control: ahb-lite registers, sync, edge events, irq
// assumes a single ahb-lite master, the analog core and the timer outside
`timescale 1ns/10ps
`include "acc_map.svh"
module acc_top #(
   parameter int SYNC_STAGES = `ACC_SYNC_STAGES
) (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic COMP_RAW,
   input wire logic GLOBAL_IRQ_EN,
   input wire logic IRQ_VECTOR_ACK,
   output logic COMP_POWER_OFF,
   output logic POS_BANDGAP_SEL,
   output logic NEG_MUX_SEL,
   output logic [2:0] NEG_CHANNEL,
   output logic CAPTURE_TRIGGER,
   output logic IRQ
);

   // ***************************************************************
   // elaboration check
   // ***************************************************************
   generate
      if (SYNC_STAGES != 2) begin : g_bad_sync
         $error("acc_top result delay needs exactly two sync stages");
      end
   endgenerate

   // ***************************************************************
   // register decode
   // ***************************************************************
   // one-hot select of the five words; shared by read and write paths
   function automatic logic [4:0] reg_sel(input logic [9:0] idx);
      logic [4:0] s;
      s = 5'h00;
      case (idx)
         `ACC_IDX_CSR: s = 5'h01;
         `ACC_IDX_CTLB: s = 5'h02;
         `ACC_IDX_MUX: s = 5'h04;
         `ACC_IDX_ISTAT: s = 5'h08;
         `ACC_IDX_IMASK: s = 5'h10;
         default: s = 5'h00;
      endcase
      return s;
   endfunction

   // ***************************************************************
   // bus state
   // ***************************************************************
   logic addr_ok; // valid address phase this cycle
   logic wr_pend_r; // write data phase pending
   logic [9:0] wr_idx_r; // word index of pending write
   logic [4:0] wr_sel; // decoded pending write
   logic [4:0] rd_sel; // decoded read in address phase
   logic [31:0] hrdata_r; // registered read data
   logic [31:0] rd_word; // read value built from next state

   // ***************************************************************
   // control and status state
   // ***************************************************************
   logic power_off_r, power_off_nxt; // comparator switched off
   logic bandgap_r, bandgap_nxt; // bandgap feeds positive input
   logic flag_r, flag_nxt; // sticky event flag
   logic irq_en_r, irq_en_nxt; // comparator interrupt enable
   logic route_r, route_nxt; // result routed to timer capture
   logic [1:0] mode_r, mode_nxt; // edge mode field
   logic mux_en_r, mux_en_nxt; // negative mux enable
   logic [2:0] trig_r, trig_nxt; // stored trigger source, no effect here
   logic [2:0] chan_r, chan_nxt; // channel select
   logic conv_en_r, conv_en_nxt; // converter enable
   logic power_reduce_r, power_reduce_nxt; // converter power reduce
   logic result; // synchronised result
   logic prev_r; // previous synchronised sample
   logic rise_ev, fall_ev; // edges of the result
   logic event_set; // selected event this cycle
   logic flag_clear; // any clearing source this cycle
   logic neg_mux_r; // registered mux select output
   logic [2:0] neg_chan_r; // registered channel output
   logic capture_r; // registered capture trigger
   logic irq_r; // registered interrupt request
   logic hreadyout_r; // registered ready
   logic hresp_r; // registered response, always okay
   logic sync_in; // raw level gated by power off

   assign addr_ok = HSEL & HREADY & HTRANS[1];
   assign wr_sel = wr_pend_r ? reg_sel(wr_idx_r) : 5'h00;
   assign rd_sel = (addr_ok & !HWRITE) ? reg_sel(HADDR[11:2]) : 5'h00;

   // ***************************************************************
   // ahb-lite address phase capture
   // ***************************************************************
   // zero wait states; writes land at the end of their data phase
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         wr_pend_r <= 1'b0;
         wr_idx_r <= 10'h000;
      end else if (HREADY) begin
         wr_pend_r <= addr_ok & HWRITE;
         wr_idx_r <= HADDR[11:2];
      end
   end

   // ready is always high, response is always okay
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end else begin
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end
   end

   // ***************************************************************
   // comparator result synchroniser
   // ***************************************************************
   // the gate sits before the chain; switching power off can thus
   // produce an edge, the reason software must mask first
   assign sync_in = COMP_RAW & !power_off_r;
   acc_sync #(
      .STAGES(SYNC_STAGES)
   ) u_sync (
      .clk(CLOCK),
      .rst_b(RST_B),
      .d_in(sync_in),
      .q_out(result)
   );

   // previous sample kept for edge detection
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= result;
      end
   end

   // ***************************************************************
   // event selection
   // ***************************************************************
   assign rise_ev = result & !prev_r;
   assign fall_ev = !result & prev_r;

   // mode picks the event; reserved code never sets the flag
   always_comb begin
      event_set = 1'b0;
      case (acc_pkg::acc_edge_mode_type'(mode_r))
         acc_pkg::ACC_EDGE_TOGGLE: event_set = rise_ev | fall_ev;
         acc_pkg::ACC_EDGE_FALL: event_set = fall_ev;
         acc_pkg::ACC_EDGE_RISE: event_set = rise_ev;
         default: event_set = 1'b0; // reserved code
      endcase
   end

   // ***************************************************************
   // next state of software visible bits
   // ***************************************************************
   // flag clears by vector ack or a one written; a set in the same
   // cycle wins so no event is lost
   always_comb begin
      flag_clear = IRQ_VECTOR_ACK;
      if (wr_sel[0] && HWDATA[`ACC_CSR_FLAG]) begin
         flag_clear = 1'b1;
      end
      if (wr_sel[3] && HWDATA[`ACC_IRQ_BIT]) begin
         flag_clear = 1'b1;
      end
      flag_nxt = event_set | (flag_r & !flag_clear);
   end

   // comparator control word and interrupt mask alias
   always_comb begin
      power_off_nxt = power_off_r;
      bandgap_nxt = bandgap_r;
      irq_en_nxt = irq_en_r;
      route_nxt = route_r;
      mode_nxt = mode_r;
      if (wr_sel[0]) begin
         power_off_nxt = HWDATA[`ACC_CSR_POWER_OFF]; // any time
         bandgap_nxt = HWDATA[`ACC_CSR_BANDGAP];
         irq_en_nxt = HWDATA[`ACC_CSR_IRQ_EN];
         route_nxt = HWDATA[`ACC_CSR_ROUTE];
         mode_nxt = HWDATA[1:0];
      end else if (wr_sel[4]) begin
         irq_en_nxt = HWDATA[`ACC_IRQ_BIT]; // mask alias
      end
   end

   // control b keeps only bit six and bits two to zero
   always_comb begin
      mux_en_nxt = mux_en_r;
      trig_nxt = trig_r;
      if (wr_sel[1]) begin
         mux_en_nxt = HWDATA[`ACC_CTLB_MUX_EN];
         trig_nxt = HWDATA[2:0]; // other bits dropped
      end
   end

   // mux word stands in for the converter control bits
   always_comb begin
      chan_nxt = chan_r;
      conv_en_nxt = conv_en_r;
      power_reduce_nxt = power_reduce_r;
      if (wr_sel[2]) begin
         chan_nxt = HWDATA[2:0];
         conv_en_nxt = HWDATA[`ACC_MUX_CONV_EN];
         power_reduce_nxt = HWDATA[`ACC_MUX_POWER_REDUCE];
      end
   end

   // ***************************************************************
   // register flops
   // ***************************************************************
   // comparator control and status
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         power_off_r <= 1'(`ACC_CSR_RESET >> `ACC_CSR_POWER_OFF);
         bandgap_r <= 1'b0;
         flag_r <= 1'b0;
         irq_en_r <= 1'b0;
         route_r <= 1'b0;
         mode_r <= 2'h0;
      end else begin
         power_off_r <= power_off_nxt;
         bandgap_r <= bandgap_nxt;
         flag_r <= flag_nxt;
         irq_en_r <= irq_en_nxt;
         route_r <= route_nxt;
         mode_r <= mode_nxt;
      end
   end

   // control b and mux word
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         mux_en_r <= 1'b0;
         trig_r <= 3'h0;
         chan_r <= 3'h0;
         conv_en_r <= 1'b0;
         power_reduce_r <= 1'b0;
      end else begin
         mux_en_r <= mux_en_nxt;
         trig_r <= trig_nxt;
         chan_r <= chan_nxt;
         conv_en_r <= conv_en_nxt;
         power_reduce_r <= power_reduce_nxt;
      end
   end

   // ***************************************************************
   // read path
   // ***************************************************************
   // built from next state so a read right after a write sees it
   always_comb begin
      rd_word = 32'h0000_0000;
      case (rd_sel)
         5'h01: rd_word = {24'h00_0000, power_off_nxt, bandgap_nxt, result,
                           flag_nxt, irq_en_nxt, route_nxt, mode_nxt};
         5'h02: rd_word = {25'h000_0000, mux_en_nxt, 3'h0, trig_nxt};
         5'h04: rd_word = {27'h000_0000, power_reduce_nxt, conv_en_nxt, chan_nxt};
         5'h08: rd_word = {31'h0000_0000, flag_nxt};
         5'h10: rd_word = {31'h0000_0000, irq_en_nxt};
         default: rd_word = 32'h0000_0000; // unmapped reads zero
      endcase
   end

   // read data registered into the data phase
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         hrdata_r <= 32'h0000_0000;
      end else if (HREADY) begin
         hrdata_r <= rd_word;
      end
   end

   // ***************************************************************
   // analog steering outputs
   // ***************************************************************
   // mux select needs enable, converter off and no power reduce
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         neg_mux_r <= 1'b0;
         neg_chan_r <= 3'h0;
      end else begin
         neg_mux_r <= mux_en_r & !conv_en_r & !power_reduce_r;
         neg_chan_r <= chan_r; // 000 channel 0 .. 111 channel 7
      end
   end

   // capture route; no connection at all while the bit is clear.
   // the timer's own capture enable is still needed for its irq
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         capture_r <= 1'b0;
      end else begin
         capture_r <= route_r & result;
      end
   end

   // ***************************************************************
   // interrupt request
   // ***************************************************************
   // level request; software masks before mode changes
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= flag_r & irq_en_r & GLOBAL_IRQ_EN;
      end
   end

   // ***************************************************************
   // output assignments
   // ***************************************************************
   assign HRDATA = hrdata_r;
   assign HREADYOUT = hreadyout_r;
   assign HRESP = hresp_r;
   assign COMP_POWER_OFF = power_off_r;
   assign POS_BANDGAP_SEL = bandgap_r;
   assign NEG_MUX_SEL = neg_mux_r;
   assign NEG_CHANNEL = neg_chan_r;
   assign CAPTURE_TRIGGER = capture_r;
   assign IRQ = irq_r;

   // ***************************************************************
   // assertions
   // ***************************************************************
   a_result_sync: assert property (@(posedge CLOCK) disable iff (!RST_B)
      ##2 result == $past(sync_in, 2))
      else $error("result not two cycles behind raw input");

   a_result_high: assert property (@(posedge CLOCK) disable iff (!RST_B)
      (COMP_RAW && !power_off_r) [*3] |-> result)
      else $error("steady high comparison not shown as high");

   a_neg_mux: assert property (@(posedge CLOCK) disable iff (!RST_B)
      ##1 NEG_MUX_SEL == ($past(mux_en_r) && !$past(conv_en_r) && !$past(power_reduce_r)))
      else $error("negative mux select wrong");

   a_mux_power: assert property (@(posedge CLOCK) disable iff (!RST_B)
      power_reduce_r |=> !NEG_MUX_SEL)
      else $error("mux used under power reduce");

   a_power_off: assert property (@(posedge CLOCK) disable iff (!RST_B)
      wr_sel[0] && HWDATA[7] |=> COMP_POWER_OFF)
      else $error("power off write not taken");

   a_bandgap_sel: assert property (@(posedge CLOCK) disable iff (!RST_B)
      wr_sel[0] |=> POS_BANDGAP_SEL == $past(HWDATA[6]))
      else $error("bandgap select does not follow write");

   a_mode_reserved: assert property (@(posedge CLOCK) disable iff (!RST_B)
      mode_r == 2'b01 && !flag_r |=> !flag_r)
      else $error("reserved mode set the flag");

   a_flag_set: assert property (@(posedge CLOCK) disable iff (!RST_B)
      (mode_r == 2'b11 && result && !prev_r) |=> flag_r)
      else $error("rising edge lost");

   a_flag_ack: assert property (@(posedge CLOCK) disable iff (!RST_B)
      IRQ_VECTOR_ACK && !event_set |=> !flag_r)
      else $error("vector ack did not clear flag");

   a_zero_keeps: assert property (@(posedge CLOCK) disable iff (!RST_B)
      flag_r && wr_sel[0] && !HWDATA[4] && !IRQ_VECTOR_ACK |=> flag_r)
      else $error("zero write changed flag");

   a_irq_level: assert property (@(posedge CLOCK) disable iff (!RST_B)
      !irq_en_r |=> !IRQ)
      else $error("irq without enable");

   a_capture_off: assert property (@(posedge CLOCK) disable iff (!RST_B)
      !route_r |=> !CAPTURE_TRIGGER)
      else $error("capture driven while not routed");

   a_prev_sample: assert property (@(posedge CLOCK) disable iff (!RST_B)
      ##1 prev_r == $past(result))
      else $error("previous sample stale");

   a_ctlb_zero: assert property (@(posedge CLOCK) disable iff (!RST_B)
      rd_sel == 5'h02 |=> HRDATA[7] == 1'b0 && HRDATA[5:3] == 3'h0)
      else $error("unused control b bits read nonzero");

endmodule

// ---- tb/acc_far_model.sv ----
// far-side model: analog comparator core and timer capture front end
// assumes voltages in millivolts come from the bench as plain integers
`timescale 1ns/10ps
module acc_far_model #(
   parameter int BANDGAP_MV = 1000
) (
   input wire logic clk,
   input var int pos_pin_mv,
   input var int neg_pin_mv,
   input var int chan_mv [8],
   input wire logic power_off,
   input wire logic bandgap_sel,
   input wire logic mux_sel,
   input wire logic [2:0] channel,
   input wire logic capture_trigger,
   input wire logic capture_irq_enable,
   output logic comp_raw,
   output int capture_cnt,
   output logic capture_irq
);
   // ***************************************************************
   // analog side
   // ***************************************************************
   int pos_mv; // level on the positive input
   int neg_mv; // level on the negative input
   int cap_cnt = 0; // rising edges seen by the capture front end
   logic idle_tog = 1'b0; // junk pattern while powered down
   logic cap_prev = 1'b0; // last capture input sample
   assign pos_mv = bandgap_sel ? BANDGAP_MV : pos_pin_mv;
   assign neg_mv = mux_sel ? chan_mv[channel] : neg_pin_mv;
   // an unpowered comparator has no valid level, so it toggles freely
   assign comp_raw = power_off ? idle_tog : (pos_mv > neg_mv);
   // capture front end with rising edge select
   always @(posedge clk) begin
      idle_tog <= ~idle_tog;
      cap_prev <= capture_trigger;
      if (capture_trigger && !cap_prev) begin
         cap_cnt <= cap_cnt + 1;
      end
   end
   assign capture_cnt = cap_cnt;
   // capture interrupt only with its own enable
   assign capture_irq = capture_irq_enable && (cap_cnt != 0);
endmodule

// ---- tb/tb_acc_top.sv ----
// self-checking bench for the analog compare control block
// assumes the far-side model file and the design files are compiled first
`timescale 1ns/10ps
`include "acc_map.svh"
module tb_acc_top;
   // ***************************************************************
   // byte addresses and bench state
   // ***************************************************************
   localparam logic [31:0] A_CSR = {20'h0, `ACC_IDX_CSR, 2'b00};
   localparam logic [31:0] A_CTLB = {20'h0, `ACC_IDX_CTLB, 2'b00};
   localparam logic [31:0] A_MUX = {20'h0, `ACC_IDX_MUX, 2'b00};
   localparam logic [31:0] A_ISTAT = {20'h0, `ACC_IDX_ISTAT, 2'b00};
   localparam logic [31:0] A_IMASK = {20'h0, `ACC_IDX_IMASK, 2'b00};
   localparam logic [31:0] A_NONE = 32'h0000_0100; // unmapped word
   localparam int BG_MV = 1000; // bandgap level in the model
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic hready, hresp, comp_raw, pwr_off, bg_sel, mux_sel, cap_trig, irq;
   logic glob_en = 1'b0;
   logic vec_ack = 1'b0;
   logic [2:0] chan;
   int pos_mv = 500;
   int neg_mv = 600;
   int ch_mv [8];
   int cap_cnt, cc;
   int error_cnt = 0;
   int checks = 0;
   int m_ctl = 0, m_ctlb = 0, m_mux = 0, m_flag = 0, m_res = 0; // model
   always #10 clk = ~clk;
   acc_top acc_top_inst (.CLOCK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .COMP_RAW(comp_raw),
      .GLOBAL_IRQ_EN(glob_en), .IRQ_VECTOR_ACK(vec_ack), .COMP_POWER_OFF(pwr_off),
      .POS_BANDGAP_SEL(bg_sel), .NEG_MUX_SEL(mux_sel), .NEG_CHANNEL(chan),
      .CAPTURE_TRIGGER(cap_trig), .IRQ(irq));
   acc_far_model #(.BANDGAP_MV(BG_MV)) acc_far_model_inst (.clk(clk), .pos_pin_mv(pos_mv),
      .neg_pin_mv(neg_mv), .chan_mv(ch_mv), .power_off(pwr_off), .bandgap_sel(bg_sel),
      .mux_sel(mux_sel), .channel(chan), .capture_trigger(cap_trig),
      .capture_irq_enable(1'b1), .comp_raw(comp_raw), .capture_cnt(cap_cnt),
      .capture_irq());
   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one single transfer; entered just after a rising edge
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // expected comparator level from the model's register copies
   function automatic int calc();
      int p;
      int n;
      p = (m_ctl & 'h40) ? BG_MV : pos_mv;
      n = ((m_ctlb & 'h40) && !(m_mux & 'h18)) ? ch_mv[m_mux & 7] : neg_mv;
      return (m_ctl & 'h80) ? 0 : int'(p > n);
   endfunction
   // event detection from previous versus new level
   task automatic upd(input int r);
      int prev;
      int md;
      prev = m_res;
      md = m_ctl & 3;
      m_res = r;
      if ((md == 0 && prev != r) || (md == 2 && prev && !r) || (md == 3 && !prev && r)) begin
         m_flag = 1;
      end
   endtask
   function automatic logic [31:0] exp_csr();
      return 32'(m_ctl | (m_res << 5) | (m_flag << 4));
   endfunction
   // register write plus model update; the wait covers sync latency
   task automatic w(input logic [31:0] a, input int d);
      bus(1'b1, a, 32'(d));
      if (a == A_CSR) m_ctl = d & 'hcf;
      if (a == A_CSR && (d & 'h10)) m_flag = 0;
      if (a == A_CTLB) m_ctlb = d & 'h47;
      if (a == A_MUX) m_mux = d & 'h1f;
      if (a == A_ISTAT && (d & 1)) m_flag = 0;
      if (a == A_IMASK) m_ctl = (m_ctl & 'hf7) | ((d & 1) << 3);
      cyc(5);
      upd(calc());
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
      chk(hresp, 32'h0);
   endtask
   task automatic setv(input int p, input int n);
      pos_mv <= p;
      neg_mv <= n;
      cyc(5);
      upd(calc());
   endtask
   function automatic logic [31:0] exp_irq();
      return 32'(m_flag && (m_ctl & 8) && glob_en);
   endfunction
   // ***************************************************************
   // watchdog and main sequence
   // ***************************************************************
   initial begin
      #100000;
      error_cnt++;
      $display("watchdog expired");
      end_sim();
   end
   initial begin
      void'($urandom(51));
      for (int i = 0; i < 8; i++) ch_mv[i] = $urandom_range(1000);
      cyc(2);
      rst_b <= 1'b1;
      cyc(1);
      rchk(A_CSR, exp_csr());
      rchk(A_NONE, 32'h0);
      w(A_CTLB, 'hff);
      rchk(A_CTLB, 32'h47);
      $display("test registers done");
      for (int c = 0; c < 8; c++) begin
         w(A_MUX, c);
         chk(mux_sel, 32'h1);
         chk(chan, 32'(c));
         rchk(A_CSR, exp_csr());
      end
      w(A_MUX, 'h0f);
      chk(mux_sel, 32'h0);
      w(A_MUX, 'h17);
      chk(mux_sel, 32'h0);
      rchk(A_CSR, exp_csr());
      $display("test input select done");
      // interrupt stays disabled while the mode changes
      for (int m = 0; m < 4; m++) begin
         w(A_CSR, 'h10 | m);
         setv(601 + $urandom_range(399), 600);
         rchk(A_CSR, exp_csr());
         w(A_CSR, 'h10 | m);
         setv(500, 600);
         rchk(A_CSR, exp_csr());
      end
      $display("test edge modes done");
      w(A_CSR, 'h93);
      setv(900, 600);
      chk(pwr_off, 32'h1);
      rchk(A_CSR, exp_csr());
      w(A_CSR, 'h03);
      setv(900, 950);
      w(A_CSR, 'h53);
      chk(bg_sel, 32'h1);
      rchk(A_CSR, exp_csr());
      $display("test power and bandgap done");
      w(A_CSR, 'h13);
      setv(1200, 950);
      w(A_IMASK, 1);
      chk(irq, exp_irq());
      glob_en <= 1'b1;
      cyc(2);
      chk(irq, exp_irq());
      w(A_IMASK, 0);
      chk(irq, exp_irq());
      w(A_IMASK, 1);
      chk(irq, exp_irq());
      vec_ack <= 1'b1;
      cyc(1);
      vec_ack <= 1'b0;
      cyc(2);
      m_flag = 0;
      chk(irq, exp_irq());
      rchk(A_ISTAT, 32'(m_flag));
      setv(500, 950);
      setv(1200, 950);
      w(A_ISTAT, 0);
      rchk(A_ISTAT, 32'(m_flag));
      w(A_ISTAT, 1);
      rchk(A_ISTAT, 32'(m_flag));
      chk(irq, exp_irq());
      $display("test interrupt done");
      w(A_CSR, 'h03);
      setv(500, 950);
      w(A_CSR, 'h07);
      cc = cap_cnt;
      setv(1200, 950);
      chk(cap_cnt, 32'(cc + 1));
      chk(cap_trig, 32'h1);
      w(A_CSR, 'h03);
      chk(cap_trig, 32'h0);
      setv(500, 950);
      setv(1200, 950);
      chk(cap_cnt, 32'(cc + 1));
      $display("test capture route done");
      end_sim();
   end
endmodule
